// >>> core/isp_boot_security_control.sv
// Program-memory control, forced boot and security logic with APB registers
//
// Added by the designer: register access over APB.
module isp_boot_security_control #(
   parameter logic [7:0] IDENT_CODE = isp_pkg::IDENT_DEFAULT,
   parameter logic [7:0] ENCRYPT_KEY = isp_pkg::ENCRYPT_KEY_DEFAULT,
   parameter logic [7:0] SECURITY_INIT = isp_pkg::SECURITY_ERASED
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [isp_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic strap_pin_a,
   input wire logic strap_pin_b,
   input wire logic strap_pin_c,
   input wire logic idle_mode,
   input wire logic wake_interrupt,
   input wire logic op_request,
   input wire logic erase_all_request,
   input wire logic table_read_from_internal,
   input wire logic loader_access,
   input wire logic [15:0] loader_addr,
   input wire logic [7:0] port0_raw,
   output logic [7:0] port0_data,
   output logic controller_reset,
   output logic core_hold,
   output logic exec_loader_bank,
   output logic rewrite_target_loader,
   output logic aux_ram_enable,
   output logic isp_mode,
   output logic pc_clear,
   output logic op_grant,
   output logic op_refused,
   output logic table_read_internal_ok,
   output logic security_selected,
   output logic external_access_block,
   output logic osc_low_gain,
   output logic encrypt_active
);
   import isp_pkg::*;

   logic [7:0] control;
   logic [7:0] security;
   logic reboot;
   logic forced_loader_boot;
   logic [1:0] settle_count;
   logic [2:0] strap_sync1;
   logic [2:0] strap_sync2;
   unlock_e unlock_state;
   isp_e isp_state;

   logic setup_phase;
   logic access_ok;
   logic [7:0] idx;
   logic aligned;
   logic mapped;
   logic special;
   logic refuse;
   logic wr_control;
   logic wr_unlock;
   logic wr_security;
   logic op_allowed;
   logic [7:0] control_read;
   logic [7:0] status_read;
   logic [7:0] read_byte;

   assign setup_phase = psel & ~penable;
   assign access_ok = psel & penable & ~pslverr;
   assign idx = paddr[9:2];
   assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
   assign mapped = aligned && (idx == IDX_CONTROL || idx == IDX_UNLOCK ||
      idx == IDX_SECURITY || idx == IDX_IDENT || idx == IDX_STATUS);
   assign special = (idx == IDX_SECURITY) || (idx == IDX_IDENT);
   assign refuse = special && (isp_state == PROGRAMMING);
   assign wr_control = access_ok && pwrite && idx == IDX_CONTROL && unlock_state == OPEN;
   assign wr_unlock = access_ok && pwrite && idx == IDX_UNLOCK;
   assign wr_security = access_ok && pwrite && idx == IDX_SECURITY;
   // Operations only while idle inside programming mode with enable still set
   assign op_allowed = (isp_state == PROGRAMMING) && control[CTL_PROGEN] && idle_mode;

   // Bit 7 reads the forced boot flag, not the stored reboot request
   assign control_read = {forced_loader_boot, 2'b00, control[CTL_AUXRAM], 2'b00,
      control[CTL_LOADSEL], control[CTL_PROGEN]};
   assign status_read = {2'b00, isp_state, exec_loader_bank, forced_loader_boot,
      (unlock_state == OPEN), core_hold};

   always_comb begin
      read_byte = 8'h00;
      unique case (idx)
         IDX_CONTROL: read_byte = control_read;
         IDX_UNLOCK: read_byte = {7'h00, unlock_state == OPEN};
         IDX_SECURITY: read_byte = security;
         IDX_IDENT: read_byte = IDENT_CODE;
         IDX_STATUS: read_byte = status_read;
         default: read_byte = 8'h00;
      endcase
   end

   // APB answer: data and error registered in setup, zero wait states
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (setup_phase) begin
            pslverr <= ~mapped | refuse;
            prdata <= (mapped && !refuse && !pwrite) ? {24'h00_0000, read_byte} : 32'h0000_0000;
         end else if (!psel) begin
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Straps cross in from board pins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_sync1 <= 3'h7;
         strap_sync2 <= 3'h7;
      end else begin
         strap_sync1 <= {strap_pin_c, strap_pin_b, strap_pin_a};
         strap_sync2 <= strap_sync1;
      end
   end

   // Reboot request lasts one cycle and re-runs the power-on sequence
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reboot <= 1'b0;
      end else begin
         reboot <= wr_control && pwdata[CTL_REBOOT] && pwdata[CTL_LOADSEL] &&
            pwdata[CTL_PROGEN];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         controller_reset <= 1'b0;
      end else begin
         controller_reset <= reboot;
      end
   end

   // Straps caught once the synchroniser has filled with pin levels
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         settle_count <= STRAP_SETTLE;
         forced_loader_boot <= 1'b0;
         core_hold <= 1'b1;
      end else if (reboot) begin
         settle_count <= STRAP_SETTLE;
         forced_loader_boot <= 1'b0;
         core_hold <= 1'b1;
      end else if (settle_count != 2'h0) begin
         settle_count <= settle_count - 2'h1;
         if (settle_count == 2'h1) begin
            forced_loader_boot <= (~strap_sync2[0] & ~strap_sync2[1]) | ~strap_sync2[2];
            core_hold <= 1'b0;
         end
      end
   end

   // Control register: only the aux RAM, loader select and program enable bits are kept
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         control <= CONTROL_RESET;
      end else if (reboot) begin
         control <= CONTROL_RESET;
      end else if (wr_control) begin
         control <= CONTROL_RESET;
         control[CTL_AUXRAM] <= pwdata[CTL_AUXRAM];
         control[CTL_LOADSEL] <= pwdata[CTL_LOADSEL];
         control[CTL_PROGEN] <= pwdata[CTL_PROGEN];
      end
   end

   // Two-key unlock; any other value closes it again
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         unlock_state <= LOCKED;
      end else if (reboot) begin
         unlock_state <= LOCKED;
      end else if (wr_unlock) begin
         if (pwdata[7:0] == UNLOCK_KEY_FIRST) begin
            unlock_state <= GOT_FIRST;
         end else if (pwdata[7:0] == UNLOCK_KEY_SECOND && unlock_state == GOT_FIRST) begin
            unlock_state <= OPEN;
         end else begin
            unlock_state <= LOCKED;
         end
      end
   end

   // Programming mode entry waits for idle and then an interrupt wake
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         isp_state <= RUN;
      end else if (reboot) begin
         isp_state <= RUN;
      end else begin
         unique case (isp_state)
            RUN: begin
               if (control[CTL_PROGEN] && idle_mode) begin
                  isp_state <= ARMED;
               end
            end
            ARMED: begin
               if (!control[CTL_PROGEN]) begin
                  isp_state <= RUN;
               end else if (wake_interrupt) begin
                  isp_state <= PROGRAMMING;
               end
            end
            PROGRAMMING: begin
               if (!control[CTL_PROGEN]) begin
                  isp_state <= RUN;
               end
            end
            default: isp_state <= RUN;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         isp_mode <= 1'b0;
      end else begin
         isp_mode <= (isp_state == PROGRAMMING) && !reboot;
      end
   end

   // Execution bank and program counter clear on the bank switch
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         exec_loader_bank <= 1'b0;
         pc_clear <= 1'b0;
      end else if (reboot) begin
         exec_loader_bank <= 1'b0;
         pc_clear <= 1'b0;
      end else begin
         pc_clear <= 1'b0;
         if (settle_count == 2'h1) begin
            exec_loader_bank <= (~strap_sync2[0] & ~strap_sync2[1]) | ~strap_sync2[2];
         end else if (isp_state == ARMED && control[CTL_PROGEN] && wake_interrupt &&
                      control[CTL_LOADSEL] && !exec_loader_bank) begin
            exec_loader_bank <= 1'b1;
            pc_clear <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rewrite_target_loader <= 1'b0;
         aux_ram_enable <= 1'b0;
      end else begin
         rewrite_target_loader <= ~control[CTL_LOADSEL];
         aux_ram_enable <= control[CTL_AUXRAM];
      end
   end

   // Memory operation gate for the command logic
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         op_grant <= 1'b0;
         op_refused <= 1'b0;
      end else begin
         op_grant <= (op_request | erase_all_request) & op_allowed;
         op_refused <= (op_request | erase_all_request) & ~op_allowed;
      end
   end

   // Nonvolatile bits: a warm reboot leaves them alone; erase-all wins over a write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         security <= SECURITY_INIT;
      end else if (erase_all_request && op_allowed) begin
         security <= SECURITY_ERASED;
      end else if (wr_security) begin
         security <= security & pwdata[7:0];
      end
   end

   // Decoded protection outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         external_access_block <= 1'b1;
         osc_low_gain <= 1'b0;
         encrypt_active <= 1'b0;
         table_read_internal_ok <= 1'b0;
         security_selected <= 1'b0;
      end else begin
         external_access_block <= ~security[SEC_LOCK];
         osc_low_gain <= ~security[SEC_OSCGAIN];
         encrypt_active <= ~security[SEC_ENCRYPT];
         table_read_internal_ok <= table_read_from_internal | security[SEC_INHIBIT];
         security_selected <= loader_access && (loader_addr == SECURITY_LOADER_ADDR);
      end
   end

   // Encoding costs one register stage on port 0 either way
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port0_data <= 8'h00;
      end else if (!security[SEC_ENCRYPT]) begin
         port0_data <= port0_raw ^ ENCRYPT_KEY;
      end else begin
         port0_data <= port0_raw;
      end
   end
endmodule

// >>> core/isp_pkg.sv
// Constants, register map and state encodings for the program-memory control block
// Behaviour
// - Reboot bit written 1 with loader select and program enable 1 resets controller.
// - Reboot bit position reads 1 while running in forced loader boot.
// - Aux RAM enable bit gates the on-chip auxiliary RAM.
// - Loader select picks which bank runs the loader and which is rewritten.
// - Programming mode starts only after idle entry and interrupt wake with enable set.
// - Erase, program and read operations run only while in idle during programming mode.
// - Program enable clear makes memory read-only and blocks erase and program.
// - After power-on the first fetch is from the application bank unless forced.
// - Forced loader boot when straps a and b both low, or strap c low.
// - Special setting registers refuse access while in programming mode.
// - Security bits only go 1 to 0; only erase-all returns them to 1.
// - Security register sits at the last address of loader space.
// - Lock bit 0 blocks external access to memory and special registers.
// - Inhibit 0: external table reads never return internal memory contents.
// - Table reads run from internal memory may always read everything.
// - Inhibit 1: table reads carry no region restriction.
// - Encryption on: port 0 data passes through encoding logic.
// - Encryption bit returned to 1 only by whole-chip erase.
// - Security bit 7 at 0 selects half oscillator gain.
// - Control register writable only after 87h then 59h to unlock register.
// - Switching from application to loader bank clears the program counter.
package isp_pkg;
   localparam int ADDR_W = 12;
   localparam logic [7:0] IDX_CONTROL = 8'hbf;
   localparam logic [7:0] IDX_UNLOCK = 8'hc0;
   localparam logic [7:0] IDX_SECURITY = 8'hc1;
   localparam logic [7:0] IDX_IDENT = 8'hc2;
   localparam logic [7:0] IDX_STATUS = 8'hc3;
   localparam int CTL_REBOOT = 7;
   localparam int CTL_AUXRAM = 4;
   localparam int CTL_LOADSEL = 1;
   localparam int CTL_PROGEN = 0;
   localparam int SEC_LOCK = 0;
   localparam int SEC_INHIBIT = 1;
   localparam int SEC_ENCRYPT = 2;
   localparam int SEC_OSCGAIN = 7;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] SECURITY_ERASED = 8'hff;
   localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h87;
   localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h59;
   localparam logic [15:0] SECURITY_LOADER_ADDR = 16'hffff;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   // Arbitrary value
   localparam logic [7:0] IDENT_DEFAULT = 8'h3c;
   // Arbitrary value
   localparam logic [7:0] ENCRYPT_KEY_DEFAULT = 8'h5a;
   typedef enum logic [1:0] {
      LOCKED = 2'b00,
      GOT_FIRST = 2'b01,
      OPEN = 2'b10
   } unlock_e;
   typedef enum logic [1:0] {
      RUN = 2'b00,
      ARMED = 2'b01,
      PROGRAMMING = 2'b10
   } isp_e;
endpackage

// >>> testbench/board_straps.sv
// Board strap model holding jumper levels steady across every reset
module board_straps (
   input wire logic [1:0] mode,
   output logic strap_pin_a,
   output logic strap_pin_b,
   output logic strap_pin_c
);
   timeunit 1ns;
   timeprecision 1ps;
   // Levels only move between resets, never while one is sampled
   assign strap_pin_a = !(mode == 2'h1 || mode == 2'h3);
   assign strap_pin_b = mode != 2'h1;
   assign strap_pin_c = mode != 2'h2;
endmodule

// >>> testbench/isp_checks_assertions.sv
// Port-level checks for the program-memory control block
module isp_checks #(
   parameter logic [7:0] ENCRYPT_KEY = isp_pkg::ENCRYPT_KEY_DEFAULT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [isp_pkg::ADDR_W-1:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic idle_mode,
   input wire logic op_request,
   input wire logic table_read_from_internal,
   input wire logic loader_access,
   input wire logic [15:0] loader_addr,
   input wire logic [7:0] port0_raw,
   input wire logic [7:0] port0_data,
   input wire logic controller_reset,
   input wire logic core_hold,
   input wire logic exec_loader_bank,
   input wire logic isp_mode,
   input wire logic pc_clear,
   input wire logic op_grant,
   input wire logic op_refused,
   input wire logic table_read_internal_ok,
   input wire logic security_selected,
   input wire logic encrypt_active
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sec_hit;
   assign sec_hit = loader_access && loader_addr == 16'hffff;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_zero_wait:
      assert property (psel && !penable |=> pready) else $error("access stalled");
   a_misalign_err:
      assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr) else $error("no error");
   a_ident_refused:
      assert property (psel && penable && paddr == 12'h308 && isp_mode |-> pslverr)
      else $error("ident reachable in isp");
   a_sec_address:
      assert property (!$past(rst) |-> security_selected == $past(sec_hit))
      else $error("security select wrong");
   a_port_encoded:
      assert property (encrypt_active && $past(encrypt_active) && !$past(rst)
         |-> port0_data == ($past(port0_raw) ^ ENCRYPT_KEY)) else $error("not encoded");
   a_port_plain:
      assert property (!encrypt_active && !$past(encrypt_active) && !$past(rst)
         |-> port0_data == $past(port0_raw)) else $error("plain data altered");
   a_internal_read:
      assert property ($past(table_read_from_internal) && !$past(rst) |-> table_read_internal_ok)
      else $error("internal table read blocked");
   a_op_answer:
      assert property (op_request |=> op_grant != op_refused) else $error("op answer wrong");
   a_op_not_idle:
      assert property (op_request && !idle_mode |=> op_refused) else $error("op outside idle");
   a_pc_clear:
      assert property (pc_clear |-> exec_loader_bank ##1 !pc_clear) else $error("pc clear bad");
   a_reboot_pulse:
      assert property (controller_reset |-> core_hold ##1 !controller_reset)
      else $error("reboot pulse bad");
   a_hold_release:
      assert property ($fell(rst) |-> core_hold ##[1:5] !core_hold) else $error("hold stuck");
   c_reboot: cover property (controller_reset);
   c_switch: cover property (pc_clear);
   c_grant: cover property (op_grant);
endmodule
bind isp_boot_security_control isp_checks #(.ENCRYPT_KEY(ENCRYPT_KEY)) u_checks (
   .clk, .rst, .psel, .penable, .paddr, .pready, .pslverr, .idle_mode, .op_request,
   .table_read_from_internal, .loader_access, .loader_addr, .port0_raw, .port0_data,
   .controller_reset, .core_hold, .exec_loader_bank, .isp_mode, .pc_clear, .op_grant,
   .op_refused, .table_read_internal_ok, .security_selected, .encrypt_active);

// >>> testbench/test_isp_boot_security_control.sv
// Directed bench for the program-memory control block
`define CHK(x, y) begin check_count++; if ((x) !== (y)) begin fail_count++; \
   $display("BAD %0t got %h want %h", $time, x, y); end end
module test_isp_boot_security_control;
   timeunit 1ns;
   timeprecision 1ps;
   import isp_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 0, penable = 0, pwrite = 0, idle_mode = 0;
   logic wake_interrupt = 0, op_request = 0, erase_all_request = 0, loader_access = 0;
   logic table_read_from_internal = 0, er, g, f;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [15:0] loader_addr = 16'h0;
   logic [7:0] port0_raw = 8'h00, rd, port0_data;
   logic [1:0] mode = 2'h0;
   logic pready, pslverr, strap_pin_a, strap_pin_b, strap_pin_c, controller_reset;
   logic core_hold, exec_loader_bank, rewrite_target_loader, aux_ram_enable, isp_mode;
   logic pc_clear, op_grant, op_refused, table_read_internal_ok, security_selected;
   logic external_access_block, osc_low_gain, encrypt_active;
   int fail_count = 0, check_count = 0, reboots = 0, clears = 0;
   board_straps straps (.mode, .strap_pin_a, .strap_pin_b, .strap_pin_c);
   isp_boot_security_control DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .strap_pin_a, .strap_pin_b, .strap_pin_c, .idle_mode,
      .wake_interrupt, .op_request, .erase_all_request, .table_read_from_internal,
      .loader_access, .loader_addr, .port0_raw, .port0_data, .controller_reset, .core_hold,
      .exec_loader_bank, .rewrite_target_loader, .aux_ram_enable, .isp_mode, .pc_clear,
      .op_grant, .op_refused, .table_read_internal_ok, .security_selected,
      .external_access_block, .osc_low_gain, .encrypt_active);
   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (controller_reset === 1'b1) reboots++;
      if (pc_clear === 1'b1) clears++;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         fail_count++;
         complete_run();
      end
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdr(input logic [11:0] a);
      bus(1'b0, a, 8'h00);
   endtask
   task automatic unlock;
      wr(12'h300, 8'h87);
      wr(12'h300, 8'h59);
   endtask
   // Grant or refusal may land in either of the two following cycles
   task automatic op;
      g = 1'b0;
      f = 1'b0;
      op_request <= 1'b1;
      cyc(1);
      op_request <= 1'b0;
      repeat (2) begin
         g |= op_grant === 1'b1;
         f |= op_refused === 1'b1;
         cyc(1);
      end
   endtask
   task automatic t_reset;
      rdr(12'h2fc);
      `CHK(rd, 8'h00)
      `CHK({exec_loader_bank, external_access_block, encrypt_active}, 3'b000)
      `CHK(table_read_internal_ok, 1'b1)
      rdr(12'h308);
      `CHK(rd, IDENT_DEFAULT)
      rdr(12'h010);
      `CHK(er, 1'b1)
      rdr(12'h2fd);
      `CHK(er, 1'b1)
   endtask
   task automatic t_unlock;
      wr(12'h2fc, 8'h10);
      wr(12'h300, 8'h59);
      wr(12'h2fc, 8'h10);
      rdr(12'h2fc);
      `CHK(rd, 8'h00)
      unlock();
      rdr(12'h300);
      `CHK(rd, 8'h01)
      wr(12'h2fc, 8'h10);
      cyc(2);
      `CHK(aux_ram_enable, 1'b1)
      wr(12'h300, 8'h33);
      wr(12'h2fc, 8'h00);
      rdr(12'h2fc);
      `CHK(rd, 8'h10)
   endtask
   task automatic t_security;
      wr(12'h304, 8'hfe);
      wr(12'h304, 8'hff);
      rdr(12'h304);
      `CHK(rd, 8'hfe)
      `CHK(external_access_block, 1'b1)
      wr(12'h304, 8'h79);
      port0_raw <= 8'hc3;
      cyc(3);
      `CHK({table_read_internal_ok, encrypt_active, osc_low_gain}, 3'b011)
      `CHK(port0_data, 8'h99)
      table_read_from_internal <= 1'b1;
      loader_access <= 1'b1;
      loader_addr <= 16'hffff;
      cyc(2);
      `CHK({table_read_internal_ok, security_selected}, 2'b11)
      loader_addr <= 16'hfffe;
      cyc(2);
      `CHK(security_selected, 1'b0)
   endtask
   task automatic t_isp;
      unlock();
      wr(12'h2fc, 8'h03);
      cyc(2);
      `CHK({rewrite_target_loader, aux_ram_enable}, 2'b00)
      op();
      `CHK({g, f}, 2'b01)
      idle_mode <= 1'b1;
      cyc(2);
      op();
      `CHK({g, f, isp_mode}, 3'b010)
      wake_interrupt <= 1'b1;
      cyc(1);
      wake_interrupt <= 1'b0;
      cyc(2);
      `CHK({isp_mode, exec_loader_bank}, 2'b11)
      `CHK(clears, 1)
      op();
      `CHK({g, f}, 2'b10)
      rdr(12'h308);
      `CHK(er, 1'b1)
      idle_mode <= 1'b0;
      op();
      `CHK({g, f}, 2'b01)
      idle_mode <= 1'b1;
      erase_all_request <= 1'b1;
      cyc(1);
      erase_all_request <= 1'b0;
      wr(12'h2fc, 8'h00);
      cyc(3);
      `CHK({isp_mode, rewrite_target_loader}, 2'b01)
      op();
      `CHK({g, f}, 2'b01)
      rdr(12'h304);
      `CHK(rd, 8'hff)
      idle_mode <= 1'b0;
   endtask
   task automatic t_reboot;
      int i;
      for (int k = 0; k < 4; k++) begin
         mode <= k[1:0];
         unlock();
         wr(12'h2fc, 8'h83);
         for (i = 0; i < 20 && !(reboots > k && core_hold === 1'b0); i++) cyc(1);
         if (i == 20) begin
            fail_count++;
            complete_run();
         end
         `CHK(reboots, k + 1)
         `CHK(exec_loader_bank, 1'(k == 1 || k == 2))
         rdr(12'h2fc);
         `CHK(rd, {k == 1 || k == 2, 7'h00})
      end
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      cyc(5);
      t_reset();
      t_unlock();
      t_security();
      t_isp();
      t_reboot();
      complete_run();
   end
endmodule
